/* core/smie_cfg.svh */
// constants for the shift, move and indirect load execution block
`ifndef SMIE_CFG_SVH
`define SMIE_CFG_SVH

// register byte offsets on the avalon slave
`define SMIE_ADDR_W        5
`define SMIE_OFS_CMD       5'h00
`define SMIE_OFS_WREG      5'h04
`define SMIE_OFS_PTR0      5'h08
`define SMIE_OFS_PTR1      5'h0C
`define SMIE_OFS_STAT      5'h10

// command word fields
`define SMIE_CMD_OP_LSB    0
`define SMIE_CMD_F_LSB     2
`define SMIE_CMD_D_BIT     9
`define SMIE_CMD_N_BIT     10
`define SMIE_CMD_MODE_LSB  11
`define SMIE_CMD_REL_BIT   13
`define SMIE_CMD_K_LSB     14

// status word fields
`define SMIE_STAT_C_BIT    0
`define SMIE_STAT_Z_BIT    1
`define SMIE_STAT_BUSY_BIT 2

// file addresses of the two indirect windows
`define SMIE_IND0_ADDR     7'h00
`define SMIE_IND1_ADDR     7'h01

// pointer mode codes
`define SMIE_MODE_PREINC   2'h0
`define SMIE_MODE_PREDEC   2'h1

// reset values
`define SMIE_WREG_RST      8'h00
`define SMIE_PTR_RST       16'h0000

`endif

/* core/smie_pkg.sv */
// types shared by the execution block
`default_nettype none
package smie_pkg;
   typedef enum logic [1:0] {
      SMIE_LOGICAL_SHIFT_LEFT_OP  = 2'h0,
      SMIE_LOGICAL_SHIFT_RIGHT_OP = 2'h1,
      SMIE_MOVE_FILE_REG_OP       = 2'h2,
      SMIE_INDIRECT_LOAD_OP       = 2'h3
   } smie_op_type;

   typedef enum logic [1:0] {
      SMIE_ST_IDLE = 2'h0,
      SMIE_ST_RD   = 2'h1,
      SMIE_ST_EXE  = 2'h2,
      SMIE_ST_WB   = 2'h3
   } smie_state_type;
endpackage
`default_nettype wire

/* core/smie_alu.sv */
// combinational shift and move unit
`default_nettype none
module smie_alu (
   input  wire logic [1:0] op_i,
   input  wire logic [7:0] src_i,
   output logic      [7:0] result_o,
   output logic            carry_o,
   output logic            carry_we_o,
   output logic            zero_o
);
   always_comb begin
      result_o   = src_i;
      carry_o    = 1'b0;
      carry_we_o = 1'b0;
      case (op_i)
         smie_pkg::SMIE_LOGICAL_SHIFT_LEFT_OP: begin
            result_o   = {src_i[6:0], 1'b0};
            carry_o    = src_i[7];
            carry_we_o = 1'b1;
         end
         smie_pkg::SMIE_LOGICAL_SHIFT_RIGHT_OP: begin
            result_o   = {1'b0, src_i[7:1]};
            carry_o    = src_i[0];
            carry_we_o = 1'b1;
         end
         default: begin
            result_o   = src_i;
         end
      endcase
      zero_o = (result_o == 8'h00);
   end
endmodule // smie_alu
`default_nettype wire

/* core/smie_exec.sv */
// shift, move and indirect load execution datapath with avalon slave
`include "smie_cfg.svh"
`default_nettype none

// Operation
// - left shift puts source bit 7 into carry, bits 6..0 up one, zero in.
// - right shift puts source bit 0 into carry, bits 7..1 down, zero in.
// - for shifts and moves, destination select 0 writes the working reg, 1 the file register.
// - move copies the file register to the destination and sets zero.
// - the indirect window has no storage and maps to the pointer address.
// - indirect load address is ptr+1, ptr-1 or ptr for modes 00/01/1x.
// - after the load increments leave ptr+1, decrements ptr-1.
// - relative form adds a signed -32..31 offset and keeps the pointer.
// - pointers are 16 bits and wrap around at both ends.
module smie_exec (
   input  wire logic                     clock_i,
   input  wire logic                     rst_i,
   input  wire logic [`SMIE_ADDR_W-1:0]  address_i,
   input  wire logic                     read_i,
   input  wire logic                     write_i,
   input  wire logic [31:0]              writedata_i,
   input  wire logic [3:0]               byteenable_i,
   output logic      [31:0]              readdata_o,
   output logic                          waitrequest_o,
   output logic      [15:0]              fmem_addr_o,
   output logic                          fmem_rd_o,
   output logic                          fmem_wr_o,
   output logic      [7:0]               fmem_wdata_o,
   input  wire logic [7:0]               fmem_rdata_i,
   output logic      [7:0]               wreg_o,
   output logic                          carry_o,
   output logic                          zero_o,
   output logic                          busy_o
);
   localparam logic [2:0] SEL_CMD  = 3'h0;
   localparam logic [2:0] SEL_WREG = 3'h1;
   localparam logic [2:0] SEL_PTR0 = 3'h2;
   localparam logic [2:0] SEL_PTR1 = 3'h3;
   localparam logic [2:0] SEL_STAT = 3'h4;
   localparam logic [2:0] SEL_NONE = 3'h7;

   // decoded both on the read side and on the write side
   function automatic logic [2:0] reg_sel(input logic [`SMIE_ADDR_W-1:0] a);
      logic [2:0] s;
      s = SEL_NONE;
      case (a)
         `SMIE_OFS_CMD:  s = SEL_CMD;
         `SMIE_OFS_WREG: s = SEL_WREG;
         `SMIE_OFS_PTR0: s = SEL_PTR0;
         `SMIE_OFS_PTR1: s = SEL_PTR1;
         `SMIE_OFS_STAT: s = SEL_STAT;
         default:        s = SEL_NONE;
      endcase
      return s;
   endfunction

   // byte lane merge of a write into an existing word
   function automatic logic [31:0] be_merge(input logic [31:0] old_v,
                                            input logic [31:0] new_v,
                                            input logic [3:0]  be);
      logic [31:0] r;
      r = old_v;
      for (int i = 0; i < 4; i++) begin
         if (be[i]) begin
            r[i*8 +: 8] = new_v[i*8 +: 8];
         end
      end
      return r;
   endfunction

   smie_pkg::smie_state_type state_q;

   smie_pkg::smie_op_type    op_q;
   logic [6:0]   f_q;
   logic         d_q;
   logic         n_q;
   logic [1:0]   mode_q;
   logic         rel_q;

   logic [15:0]  ptr_q [2];
   logic [7:0]   wreg_q;
   logic         carry_q;
   logic         zero_q;

   logic [15:0]  addr_q;
   logic [7:0]   wdata_q;
   logic         fwr_q;

   logic [31:0]  rdata_q;
   logic         rvalid_q;

   logic [2:0]   wsel;
   logic [2:0]   rsel;
   logic         bus_wr;
   logic         launch;

   logic [31:0]  cmd_word;
   logic [1:0]   c_op;
   logic [6:0]   c_f;
   logic         c_n;
   logic [1:0]   c_mode;
   logic         c_rel;
   logic [5:0]   c_k;

   logic [15:0]  c_base;
   logic [15:0]  eff_addr;

   logic [7:0]   alu_res;
   logic         alu_c;
   logic         alu_cwe;
   logic         alu_z;
   logic         exe;
   logic         is_ind;
   logic [31:0]  ptr_new [2];

   assign busy_o = (state_q != smie_pkg::SMIE_ST_IDLE);
   // writes stall while an operation runs so the bus never races the engine
   assign waitrequest_o = (read_i && !rvalid_q) || (write_i && busy_o);
   assign wsel   = reg_sel(address_i);
   assign rsel   = reg_sel(address_i);
   assign bus_wr = write_i && !busy_o;
   // a command write without lane 0 is dropped, the opcode lives there
   assign launch = bus_wr && (wsel == SEL_CMD) && byteenable_i[0];

   assign cmd_word = be_merge(32'h0000_0000, writedata_i, byteenable_i);
   assign c_op   = cmd_word[`SMIE_CMD_OP_LSB +: 2];
   assign c_f    = cmd_word[`SMIE_CMD_F_LSB +: 7];
   assign c_n    = cmd_word[`SMIE_CMD_N_BIT];
   assign c_mode = cmd_word[`SMIE_CMD_MODE_LSB +: 2];
   assign c_rel  = cmd_word[`SMIE_CMD_REL_BIT];
   assign c_k    = cmd_word[`SMIE_CMD_K_LSB +: 6];

   // effective address, worked out once at launch from the live pointers
   // the relative form wins over the mode field and leaves the pointer alone
   always_comb begin
      c_base   = ptr_q[c_n];
      eff_addr = {9'h000, c_f};
      if (c_op == smie_pkg::SMIE_INDIRECT_LOAD_OP) begin
         if (c_rel) begin
            eff_addr = c_base + {{10{c_k[5]}}, c_k};
         end else if (c_mode == `SMIE_MODE_PREINC) begin
            eff_addr = c_base + 16'h0001;
         end else if (c_mode == `SMIE_MODE_PREDEC) begin
            eff_addr = c_base - 16'h0001;
         end else begin
            eff_addr = c_base;
         end
      end else if (c_f == `SMIE_IND0_ADDR) begin
         eff_addr = ptr_q[0];
      end else if (c_f == `SMIE_IND1_ADDR) begin
         eff_addr = ptr_q[1];
      end
   end

   // fixed fetch, execute, write-back run; the far side cannot stall it
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         state_q <= smie_pkg::SMIE_ST_IDLE;
      end else begin
         case (state_q)
            smie_pkg::SMIE_ST_IDLE: begin
               if (launch) begin
                  state_q <= smie_pkg::SMIE_ST_RD;
               end
            end
            smie_pkg::SMIE_ST_RD:  state_q <= smie_pkg::SMIE_ST_EXE;
            smie_pkg::SMIE_ST_EXE: state_q <= smie_pkg::SMIE_ST_WB;
            smie_pkg::SMIE_ST_WB:  state_q <= smie_pkg::SMIE_ST_IDLE;
            default:               state_q <= smie_pkg::SMIE_ST_IDLE;
         endcase
      end
   end

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         op_q   <= smie_pkg::SMIE_LOGICAL_SHIFT_LEFT_OP;
         f_q    <= 7'h00;
         d_q    <= 1'b0;
         n_q    <= 1'b0;
         mode_q <= 2'h0;
         rel_q  <= 1'b0;
         addr_q <= 16'h0000;
      end else if (launch) begin
         op_q   <= smie_pkg::smie_op_type'(c_op);
         f_q    <= c_f;
         d_q    <= cmd_word[`SMIE_CMD_D_BIT];
         n_q    <= c_n;
         mode_q <= c_mode;
         rel_q  <= c_rel;
         addr_q <= eff_addr;
      end
   end

   // the file byte must come back in the cycle after the read strobe
   assign fmem_rd_o   = (state_q == smie_pkg::SMIE_ST_RD);
   assign fmem_addr_o = addr_q;
   assign exe         = (state_q == smie_pkg::SMIE_ST_EXE);
   assign is_ind      = (op_q == smie_pkg::SMIE_INDIRECT_LOAD_OP);

   smie_alu u_alu (
      .op_i       (op_q),
      .src_i      (fmem_rdata_i),
      .result_o   (alu_res),
      .carry_o    (alu_c),
      .carry_we_o (alu_cwe),
      .zero_o     (alu_z)
   );

   // file write-back, one cycle pulse in the last state
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         fwr_q   <= 1'b0;
         wdata_q <= 8'h00;
      end else begin
         fwr_q <= exe && !is_ind && d_q;
         if (exe) begin
            wdata_q <= alu_res;
         end
      end
   end

   assign fmem_wr_o    = fwr_q;
   assign fmem_wdata_o = wdata_q;

   // an indirect load always lands in the working register, whatever d says
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         wreg_q <= `SMIE_WREG_RST;
      end else if (exe && (is_ind || !d_q)) begin
         wreg_q <= alu_res;
      end else if (bus_wr && wsel == SEL_WREG && byteenable_i[0]) begin
         wreg_q <= writedata_i[7:0];
      end
   end

   assign wreg_o = wreg_q;

   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         carry_q <= 1'b0;
         zero_q  <= 1'b0;
      end else if (exe) begin
         zero_q <= alu_z;
         if (alu_cwe) begin
            carry_q <= alu_c;
         end
      end else if (bus_wr && wsel == SEL_STAT && byteenable_i[0]) begin
         // bus writes stall while busy, so this never meets an execute
         carry_q <= writedata_i[`SMIE_STAT_C_BIT];
         zero_q  <= writedata_i[`SMIE_STAT_Z_BIT];
      end
   end

   assign carry_o = carry_q;
   assign zero_o  = zero_q;

   // pointer registers; their steps never touch carry or zero
   generate
      for (genvar g = 0; g < 2; g++) begin : g_ptr
         // only lanes 0 and 1 reach a pointer, the upper half is dropped
         assign ptr_new[g] = be_merge({16'h0000, ptr_q[g]}, writedata_i,
                                      byteenable_i);
         always_ff @(posedge clock_i or posedge rst_i) begin
            if (rst_i) begin
               ptr_q[g] <= `SMIE_PTR_RST;
            end else if (exe && is_ind && !rel_q && n_q == 1'(g)) begin
               if (mode_q[0]) begin
                  ptr_q[g] <= ptr_q[g] - 16'h0001;
               end else begin
                  ptr_q[g] <= ptr_q[g] + 16'h0001;
               end
            end else if (bus_wr && wsel == (SEL_PTR0 + 3'(g))) begin
               ptr_q[g] <= ptr_new[g][15:0];
            end
         end
      end
   endgenerate

   // reads answer one cycle after they are presented
   always_ff @(posedge clock_i or posedge rst_i) begin
      if (rst_i) begin
         rvalid_q <= 1'b0;
         rdata_q  <= 32'h0000_0000;
      end else begin
         rvalid_q <= read_i && !rvalid_q;
         if (read_i && !rvalid_q) begin
            case (rsel)
               SEL_CMD:  rdata_q <= {14'h0000, 2'h0, addr_q};
               SEL_WREG: rdata_q <= {24'h000000, wreg_q};
               SEL_PTR0: rdata_q <= {16'h0000, ptr_q[0]};
               SEL_PTR1: rdata_q <= {16'h0000, ptr_q[1]};
               SEL_STAT: rdata_q <= {29'h00000000, busy_o, zero_q, carry_q};
               default:  rdata_q <= 32'h0000_0000;
            endcase
         end
      end
   end

   assign readdata_o = rdata_q;
endmodule // smie_exec
`default_nettype wire

/* verif/smie_exec_monitor.sv */
// concurrent checks on the execution block ports
`default_nettype none
module smie_exec_monitor (
   input wire logic        clock_i,
   input wire logic        rst_i,
   input wire logic [4:0]  address_i,
   input wire logic        write_i,
   input wire logic [3:0]  byteenable_i,
   input wire logic [31:0] writedata_i,
   input wire logic        waitrequest_o,
   input wire logic [15:0] fmem_addr_o,
   input wire logic        fmem_rd_o,
   input wire logic        fmem_wr_o,
   input wire logic [7:0]  fmem_wdata_o,
   input wire logic [7:0]  fmem_rdata_i,
   input wire logic [7:0]  wreg_o,
   input wire logic        carry_o,
   input wire logic        zero_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] rd_q;
   logic [1:0] op;
   logic       d;
   logic       go;
   // rd_q holds the file byte sampled in the execute cycle
   always_ff @(posedge clock_i) rd_q <= fmem_rdata_i;
   assign op = writedata_i[1:0];
   assign d = writedata_i[9];
   assign go = write_i && !waitrequest_o && byteenable_i[0]
      && address_i == 5'h00;
   default clocking @(posedge clock_i); endclocking
   default disable iff (rst_i);
   sequence rd_pulse_s;
      fmem_rd_o ##1 !fmem_rd_o;
   endsequence
   sequence fetch_s;
      go ##1 fmem_rd_o;
   endsequence
   file_read_a: assert property (go |=> rd_pulse_s)
      else $error("file read pulse missing");
   addr_hold_a: assert property (
      fetch_s |=> $stable(fmem_addr_o)[*2])
      else $error("file address moved during operation");
   lsl_result_a: assert property (go && op == 2'h0 && !d |-> ##3
      wreg_o == {rd_q[6:0], 1'b0} && carry_o == rd_q[7])
      else $error("left shift result wrong");
   lsr_result_a: assert property (go && op == 2'h1 && !d |-> ##3
      wreg_o == {1'b0, rd_q[7:1]} && carry_o == rd_q[0])
      else $error("right shift result wrong");
   file_dest_a: assert property (go && op == 2'h0 && d |-> ##3
      fmem_wr_o && fmem_wdata_o == {rd_q[6:0], 1'b0} && $stable(wreg_o))
      else $error("file destination write wrong");
   wreg_dest_a: assert property (
      go && op != 2'h3 && !d |-> ##3 !fmem_wr_o)
      else $error("file written for working destination");
   move_zero_a: assert property (go && op == 2'h2 |-> ##3
      zero_o == (rd_q == 8'h00) && $stable(carry_o))
      else $error("move flags wrong");
   load_flags_a: assert property (go && op == 2'h3 |-> ##3
      wreg_o == rd_q && zero_o == (rd_q == 8'h00) && $stable(carry_o))
      else $error("indirect load result or flags wrong");
endmodule // smie_exec_monitor

bind smie_exec smie_exec_monitor smie_exec_monitor_i (.clock_i, .rst_i,
   .address_i, .write_i, .byteenable_i, .writedata_i, .waitrequest_o,
   .fmem_addr_o, .fmem_rd_o, .fmem_wr_o, .fmem_wdata_o, .fmem_rdata_i,
   .wreg_o, .carry_o, .zero_o);
`default_nettype wire

/* verif/smie_file_model.sv */
// file register space on the far side of the block
`default_nettype none
module smie_file_model (
   input  wire logic        clock_i,
   input  wire logic [15:0] addr_i,
   input  wire logic        rd_i,
   input  wire logic        wr_i,
   input  wire logic [7:0]  wdata_i,
   output logic      [7:0]  rdata_o
);
   timeunit 1ns;
   timeprecision 1ns;
   logic [7:0] mem [65536];
   bit         seen [65536];
   logic [7:0] data_q = 8'h00;
   // unwritten bytes follow a fixed address pattern
   // data toggles outside a read so a late sample never looks valid
   always @(posedge clock_i) begin
      if (wr_i) begin
         mem[addr_i] <= wdata_i;
         seen[addr_i] <= 1'b1;
      end
      if (rd_i) data_q <= seen[addr_i] ? mem[addr_i]
         : addr_i[7:0] ^ addr_i[15:8] ^ 8'hB5;
      else data_q <= ~data_q;
   end
   assign rdata_o = data_q;
endmodule // smie_file_model
`default_nettype wire

/* verif/shift_move_indirect_exec_bench.sv */
// register level bench for the execution block
`default_nettype none
`define CHK(g, e) begin total_checks++; if ((g) !== (e)) begin \
   fail_count++; $display("unexpected at %0t: %h vs %h", $time, g, e); end end
module shift_move_indirect_exec_bench;
   timeunit 1ns;
   timeprecision 1ns;
   logic clock_i = 0, rst_i = 1, read_i = 0, write_i = 0;
   logic [4:0] address_i = 0;
   logic [31:0] writedata_i = 0, readdata_o, q;
   logic waitrequest_o, fmem_rd_o, fmem_wr_o, carry_o, zero_o, busy_o;
   logic [15:0] fmem_addr_o;
   logic [7:0] fmem_wdata_o, fmem_rdata_i, wreg_o;
   logic [15:0] ea_t [4] = '{16'h1235, 16'h1233, 16'h1234, 16'h1234};
   logic [15:0] pt_t [4] = '{16'h1235, 16'h1233, 16'h1235, 16'h1233};
   int fail_count = 0, total_checks = 0;
   initial forever #10 clock_i = ~clock_i;
   smie_exec smie_exec_i (.clock_i, .rst_i, .address_i, .read_i, .write_i,
      .writedata_i, .byteenable_i(4'hF), .readdata_o, .waitrequest_o,
      .fmem_addr_o, .fmem_rd_o, .fmem_wr_o, .fmem_wdata_o, .fmem_rdata_i,
      .wreg_o, .carry_o, .zero_o, .busy_o);
   smie_file_model smie_file_model_i (.clock_i, .addr_i(fmem_addr_o),
      .rd_i(fmem_rd_o), .wr_i(fmem_wr_o), .wdata_i(fmem_wdata_o),
      .rdata_o(fmem_rdata_i));
   function automatic logic [7:0] fn(logic [15:0] a);
      return a[7:0] ^ a[15:8] ^ 8'hB5;
   endfunction
   function automatic logic [31:0] cm(logic [1:0] o, logic [6:0] f,
      logic d, logic n, logic [1:0] m, logic r, logic [5:0] k);
      return {12'h000, k, r, m, n, d, f, o};
   endfunction
   task automatic finish_test();
      $display("checks %0d mismatches %0d", total_checks, fail_count);
      if (fail_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // request held until waitrequest is sampled low at a rising edge
   task automatic bus(input logic w, input logic [4:0] a,
      input logic [31:0] d, output logic [31:0] r);
      int n;
      @(posedge clock_i);
      address_i <= a;
      writedata_i <= d;
      write_i <= w;
      read_i <= !w;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while (waitrequest_o !== 1'b0 && n < 50);
      if (waitrequest_o !== 1'b0) begin
         fail_count++;
         finish_test();
      end else begin
         r = readdata_o;
         write_i <= 1'b0;
         read_i <= 1'b0;
      end
   endtask
   task automatic rd(input logic [4:0] a, input logic [31:0] e);
      bus(1'b0, a, 32'h0, q);
      `CHK(q, e)
   endtask
   task automatic run(input logic [31:0] c);
      bus(1'b1, 5'h00, c, q);
      @(posedge clock_i);
      `CHK(busy_o, 1'b1)
      repeat (8) begin
         bus(1'b0, 5'h10, 32'h0, q);
         if (q[2] === 1'b0) break;
      end
      `CHK(q[2], 1'b0)
   endtask
   initial begin
      repeat (8) @(posedge clock_i);
      rst_i <= 1'b0;
      rd(5'h08, 32'h0);
      rd(5'h10, 32'h0);
      bus(1'b1, 5'h10, 32'h3, q);
      rd(5'h10, 32'h3);
      rd(5'h14, 32'h0);
      run(cm(0, 7'h10, 0, 0, 0, 0, 0));
      rd(5'h04, 32'h4A);
      rd(5'h10, 32'h1);
      run(cm(1, 7'h10, 0, 0, 0, 0, 0));
      rd(5'h04, 32'h52);
      run(cm(0, 7'h35, 1, 0, 0, 0, 0));
      rd(5'h10, 32'h3);
      run(cm(2, 7'h35, 1, 0, 0, 0, 0));
      rd(5'h04, 32'h52);
      rd(5'h10, 32'h3);
      run(cm(2, 7'h10, 0, 0, 0, 0, 0));
      rd(5'h04, 32'hA5);
      for (int m = 0; m < 4; m++) begin
         bus(1'b1, 5'h0C, 32'h1234, q);
         run(cm(3, 0, 0, 1, m[1:0], 0, 0));
         rd(5'h00, {16'h0, ea_t[m]});
         rd(5'h0C, {16'h0, pt_t[m]});
         rd(5'h04, {24'h0, fn(ea_t[m])});
         rd(5'h10, 32'h1);
      end
      bus(1'b1, 5'h08, 32'h0, q);
      run(cm(3, 0, 0, 0, 1, 0, 0));
      rd(5'h00, 32'hFFFF);
      run(cm(3, 0, 0, 0, 0, 0, 0));
      rd(5'h08, 32'h0);
      bus(1'b1, 5'h0C, 32'h00D5, q);
      run(cm(3, 0, 0, 1, 0, 1, 6'h20));
      rd(5'h00, 32'h00B5);
      rd(5'h0C, 32'h00D5);
      rd(5'h10, 32'h3);
      bus(1'b1, 5'h08, 32'h0010, q);
      run(cm(2, 7'h00, 0, 0, 0, 0, 0));
      rd(5'h04, 32'hA5);
      bus(1'b1, 5'h0C, 32'h2000, q);
      run(cm(0, 7'h01, 1, 1, 0, 0, 0));
      run(cm(2, 7'h01, 0, 1, 0, 0, 0));
      rd(5'h04, 32'h2A);
      rd(5'h0C, 32'h2000);
      finish_test();
   end
endmodule // shift_move_indirect_exec_bench
`default_nettype wire
